// File: rtl/tfr_pkg.sv
/*
 * Shared constants, carriers and field decoders for the temperature
 * fault response block.
 * Assumes a single system clock domain and a one-byte command carrier.
 */
package tfr_pkg;
    // ****************************************
    // Command codes and values after reset
    // ****************************************
    localparam int         NUM_CH      = 2;     // Output channels (pages)
    localparam logic [7:0] CMD_EXT_OT  = 8'h50; // External overtemp action
    localparam logic [7:0] CMD_EXT_UT  = 8'h54; // External undertemp action
    localparam logic [7:0] CMD_INT_OT  = 8'hd6; // Internal overtemp action
    localparam logic [7:0] RST_EXT     = 8'hb8; // Paged actions after reset
    localparam logic [7:0] RST_INT     = 8'hc0; // Internal action after reset
    localparam logic [7:0] RD_NONE     = 8'h00; // Read of an unknown code

    // ****************************************
    // Field layout and encodings
    // ****************************************
    localparam int         RESP_LSB    = 6;     // Response field 7:6
    localparam int         RETRY_LSB   = 3;     // Retry field 5:3
    localparam logic [1:0] RESP_RUN    = 2'h0;  // Keep running
    localparam logic [1:0] RESP_BAD_A  = 2'h1;  // Unsupported everywhere
    localparam logic [1:0] RESP_OFF    = 2'h2;  // Disable at once
    localparam logic [1:0] RESP_HOLD   = 2'h3;  // Off while fault present
    localparam logic [2:0] RETRY_NONE  = 3'h0;  // Never restart
    localparam logic [2:0] RETRY_LOOP  = 3'h7;  // Restart without limit

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic       valid;  // One-cycle command strobe
        logic       write;  // 1 write, 0 read
        logic       page;   // Selected output channel
        logic [7:0] code;   // Command code
        logic [7:0] data;   // Single data byte
    } tfr_cmd_s;

    typedef struct packed {
        logic int_ot;       // Mask internal overtemp
        logic ext_ot;       // Mask external overtemp
        logic ext_ut;       // Mask external undertemp
        logic cml;          // Mask communication fault
    } tfr_mask_s;

    typedef struct packed {
        logic other_summary; // Summary bit in the status byte
        logic word_mfr;      // Vendor bit in the status word
        logic vendor_ot;     // Overtemp bit of vendor_fault_status
        logic byte_temp;     // Temperature bit in the status byte
        logic temp_ot;       // Overtemp bit of temperature status
        logic temp_ut;       // Undertemp bit of temperature status
    } tfr_stat_s;

    // ****************************************
    // Field decoders
    // ****************************************
    function automatic logic [1:0] resp_of(input logic [7:0] b);
        resp_of = b[RESP_LSB +: 2];
    endfunction

    function automatic logic [2:0] retry_of(input logic [7:0] b);
        retry_of = b[RETRY_LSB +: 3];
    endfunction
endpackage

// File: rtl/tfr_channel.sv
/*
 * One output channel: sticky temperature status, shutdown latches,
 * retry handling and the output enable.
 * Assumes fault levels, run level and restart ticks are synchronous.
 */
`timescale 1ns/10ps
module tfr_channel
    import tfr_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // Settings
    input  wire logic [7:0] int_cfg,
    input  wire logic [7:0] ot_cfg,
    input  wire logic [7:0] ut_cfg,
    // Events
    input  wire logic      int_fault,
    input  wire logic      ot_fault,
    input  wire logic      ut_fault,
    input  wire logic      run_on,
    input  wire logic      restart_tick,
    input  wire logic      clear_faults,
    // Results
    output tfr_stat_s      stat,
    output logic           out_enable
);
    // ****************************************
    // Decode
    // ****************************************
    logic      run_q_reg;                    // Run level, last cycle
    logic      int_lat_reg, ot_lat_reg, ut_lat_reg; // Shutdown latches
    logic      int_lat_next, ot_lat_next, ut_lat_next;
    logic      en_next;
    tfr_stat_s stat_next;
    wire       on_edge  = run_on & ~run_q_reg;   // Off then on again
    wire       clr      = clear_faults | on_edge;
    wire       int_hold = (resp_of(int_cfg) == RESP_HOLD) & int_fault;
    // Retry may release a latch only when nothing else holds the output
    wire       ot_rel   = (retry_of(ot_cfg) == RETRY_LOOP) & restart_tick & run_on
                          & ~ot_fault & ~int_lat_reg & ~ut_lat_reg & ~int_hold;
    wire       ut_rel   = (retry_of(ut_cfg) == RETRY_LOOP) & restart_tick & run_on
                          & ~ut_fault & ~int_lat_reg & ~ot_lat_reg & ~int_hold;

    // Set wins over clear on every latch and sticky bit
    assign int_lat_next = (int_fault & (resp_of(int_cfg) == RESP_OFF))
                          | (int_lat_reg & ~clr);
    assign ot_lat_next  = (ot_fault & (resp_of(ot_cfg) == RESP_OFF))
                          | (ot_lat_reg & ~clr & ~ot_rel);
    assign ut_lat_next  = (ut_fault & (resp_of(ut_cfg) == RESP_OFF))
                          | (ut_lat_reg & ~clr & ~ut_rel);
    // Response code 00 never enters any latch, so the output keeps running
    assign en_next      = run_on & ~int_lat_next & ~ot_lat_next
                          & ~ut_lat_next & ~int_hold;

    // Status is set for every response code
    assign stat_next.other_summary = int_fault | (stat.other_summary & ~clr);
    assign stat_next.word_mfr      = int_fault | (stat.word_mfr & ~clr);
    assign stat_next.vendor_ot     = int_fault | (stat.vendor_ot & ~clr);
    assign stat_next.byte_temp     = ot_fault | ut_fault
                                     | (stat.byte_temp & ~clr);
    assign stat_next.temp_ot       = ot_fault | (stat.temp_ot & ~clr);
    assign stat_next.temp_ut       = ut_fault | (stat.temp_ut & ~clr);

    // ****************************************
    // State
    // ****************************************
    // All channel state in one short process
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q_reg   <= 1'b0;
            int_lat_reg <= 1'b0;
            ot_lat_reg  <= 1'b0;
            ut_lat_reg  <= 1'b0;
            stat        <= '0;
            out_enable  <= 1'b0;
        end else begin
            run_q_reg   <= run_on;
            int_lat_reg <= int_lat_next;
            ot_lat_reg  <= ot_lat_next;
            ut_lat_reg  <= ut_lat_next;
            stat        <= stat_next;
            out_enable  <= en_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_int_off;
        int_fault && resp_of(int_cfg) == RESP_OFF;
    endsequence

    a_int_off_stays: assert property (@(posedge clk) disable iff (rst)
        s_int_off ##1 !clr [*3] |-> !out_enable)
        else $error("output came back without a clear");
    a_int_off_now: assert property (@(posedge clk) disable iff (rst)
        s_int_off |=> !out_enable)
        else $error("internal overtemp did not disable output");
    a_int_hold_back: assert property (@(posedge clk) disable iff (rst)
        int_hold |=> !out_enable)
        else $error("output enabled while fault held it off");
    a_int_status_set: assert property (@(posedge clk) disable iff (rst)
        int_fault |=> stat.other_summary && stat.word_mfr && stat.vendor_ot)
        else $error("internal overtemp status missing");
    a_ext_status_set: assert property (@(posedge clk) disable iff (rst)
        ot_fault |=> stat.byte_temp && stat.temp_ot)
        else $error("external overtemp status missing");
    a_status_sticky: assert property (@(posedge clk) disable iff (rst)
        stat.temp_ut && !clear_faults && !on_edge |=> stat.temp_ut)
        else $error("undertemp status dropped without a clear");
    a_run_code_zero: assert property (@(posedge clk) disable iff (rst)
        run_on && !int_fault && !ut_fault && !int_lat_reg && !ut_lat_reg
        && !ot_lat_reg && resp_of(ot_cfg) == RESP_RUN |=> out_enable)
        else $error("code 00 interrupted the output");
    a_retry_release: assert property (@(posedge clk) disable iff (rst)
        (ot_lat_reg && ot_rel || ut_lat_reg && ut_rel)
        && !ot_fault && !ut_fault && !int_fault |=> out_enable)
        else $error("retry tick did not restart output");
endmodule

// File: rtl/tfr_top.sv
/*
 * Temperature fault response block: holds the three action settings,
 * checks writes, answers reads, and drives status, enables and alert.
 * Assumes commands arrive as one-cycle strobes synchronous to CLOCK and
 * that the restart interval timer lives outside and pulses RESTART_TICK.
 */
// Summary of operation
// - Internal response 00 or 01 flags fault
// - Internal code 10 disables output until clear or off-on
// - Internal code 11 resumes when fault clears
// - Internal retry 000 never restarts output
// - Internal retry 001 to 111 flags fault
// - Internal delay bits have no effect
// - Internal overtemp sets three vendor status bits
// - Unmasked temperature fault asserts alert output
// - Status stays until clear, off-on, reset
// - Status set for every response code
// - External overtemp sets temperature status bits
// - External overtemp action paged, code 50, b8
// - External undertemp action paged, code 54, b8
// - Every action command carries one byte
// - Internal action unpaged, code d6, c0
// - External code 00 keeps output running
// - External 01, 11 flag fault; 10 disables
// - External retry 111 restarts on a tick, but never while the other external latch, the internal latch or the internal hold holds the output
`timescale 1ns/10ps
module tfr_top
    import tfr_pkg::*;
(
    // Clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESET,
    // Command port
    input  tfr_cmd_s               CMD,
    output logic                   RD_VALID,
    output logic [7:0]             RD_DATA,
    // Fault sources and control levels
    input  wire logic              INT_OT_FAULT,
    input  wire logic [NUM_CH-1:0] EXT_OT_FAULT,
    input  wire logic [NUM_CH-1:0] EXT_UT_FAULT,
    input  wire logic [NUM_CH-1:0] RUN_ON,
    input  wire logic [NUM_CH-1:0] RESTART_TICK,
    input  wire logic              CLEAR_FAULTS,
    input  tfr_mask_s              ALERT_MASK,
    // Results
    output logic [NUM_CH-1:0]      OUTPUT_ENABLE,
    output tfr_stat_s [NUM_CH-1:0] STATUS,
    output logic                   CML_FAULT,
    output logic                   ALERT_N
);
    // ****************************************
    // Command decode
    // ****************************************
    wire        wr     = CMD.valid & CMD.write;           // Write strobe
    wire        rd     = CMD.valid & ~CMD.write;          // Read strobe
    wire        hit_ot = CMD.code == CMD_EXT_OT;
    wire        hit_ut = CMD.code == CMD_EXT_UT;
    wire        hit_in = CMD.code == CMD_INT_OT;
    wire        hit_any = hit_ot | hit_ut | hit_in;
    wire [1:0]  w_resp  = resp_of(CMD.data);
    wire [2:0]  w_retry = retry_of(CMD.data);

    // External response codes 01 and 11 are not supported
    wire        ext_bad = (w_resp == RESP_BAD_A) | (w_resp == RESP_HOLD);
    // Internal codes below 10 and any nonzero retry are not supported;
    // delay bits 2:0 are not looked at at all
    wire        int_bad = (w_resp == RESP_RUN) | (w_resp == RESP_BAD_A)
                          | (w_retry != RETRY_NONE);

    wire        wr_ot_ok = wr & hit_ot & ~ext_bad;
    wire        wr_ut_ok = wr & hit_ut & ~ext_bad;
    wire        wr_in_ok = wr & hit_in & ~int_bad;
    // Rejected value or unknown code raises the communication fault
    wire        cml_hit  = (wr & (hit_ot | hit_ut) & ext_bad)
                           | (wr & hit_in & int_bad)
                           | (CMD.valid & ~hit_any);

    // ****************************************
    // Setting storage
    // ****************************************
    logic [7:0] int_reg;                          // Internal action, unpaged
    logic [7:0] int_next;
    logic [7:0] ot_reg [NUM_CH];                  // External overtemp, paged
    logic [7:0] ut_reg [NUM_CH];                  // External undertemp, paged
    logic [7:0] ot_next [NUM_CH];
    logic [7:0] ut_next [NUM_CH];

    // Internal setting: accepted write replaces the whole byte
    assign int_next = wr_in_ok ? CMD.data : int_reg;

    // Internal setting register
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            int_reg <= RST_INT;
        end else begin
            int_reg <= int_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_page
            // Only the selected page is touched
            assign ot_next[g] = (wr_ot_ok & (CMD.page == 1'(g))) ? CMD.data
                                                                 : ot_reg[g];
            assign ut_next[g] = (wr_ut_ok & (CMD.page == 1'(g))) ? CMD.data
                                                                 : ut_reg[g];

            // Paged setting registers
            always_ff @(posedge CLOCK or posedge RESET) begin
                if (RESET) begin
                    ot_reg[g] <= RST_EXT;
                    ut_reg[g] <= RST_EXT;
                end else begin
                    ot_reg[g] <= ot_next[g];
                    ut_reg[g] <= ut_next[g];
                end
            end

            // Per channel response logic; internal fault hits both
            tfr_channel u_ch (
                .clk          (CLOCK),
                .rst          (RESET),
                .int_cfg      (int_reg),
                .ot_cfg       (ot_reg[g]),
                .ut_cfg       (ut_reg[g]),
                .int_fault    (INT_OT_FAULT),
                .ot_fault     (EXT_OT_FAULT[g]),
                .ut_fault     (EXT_UT_FAULT[g]),
                .run_on       (RUN_ON[g]),
                .restart_tick (RESTART_TICK[g]),
                .clear_faults (CLEAR_FAULTS),
                .stat         (STATUS[g]),
                .out_enable   (OUTPUT_ENABLE[g])
            );

            // Writes to the other page leave this one alone
            a_page_apart: assert property (@(posedge CLOCK) disable iff (RESET)
                wr && (hit_ot || hit_ut) && CMD.page != 1'(g)
                |=> $stable(ot_reg[g]) && $stable(ut_reg[g]))
                else $error("write leaked into another page");
            a_ext_reject: assert property (@(posedge CLOCK) disable iff (RESET)
                wr && hit_ot && ext_bad |=> $stable(ot_reg[g]))
                else $error("unsupported external code was stored");
        end
    endgenerate

    // ****************************************
    // Read path
    // ****************************************
    logic [7:0] rd_sel;                          // Byte picked for a read
    // One byte per command; unknown codes read as zero
    assign rd_sel = hit_ot ? ot_reg[CMD.page] :
                    hit_ut ? ut_reg[CMD.page] :
                    hit_in ? int_reg : RD_NONE;

    // Read answer one cycle after the strobe
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            RD_VALID <= 1'b0;
            RD_DATA  <= RD_NONE;
        end else begin
            RD_VALID <= rd;
            RD_DATA  <= rd ? rd_sel : RD_DATA;
        end
    end

    // ****************************************
    // Communication fault and alert
    // ****************************************
    logic cml_next;
    logic alert_any;
    // Set wins over clear, so a fault in the clear cycle survives
    assign cml_next = cml_hit | (CML_FAULT & ~CLEAR_FAULTS);

    // Each source is gated by its own mask, any page counts
    always_comb begin
        alert_any = (CML_FAULT & ~ALERT_MASK.cml);
        for (int i = 0; i < NUM_CH; i++) begin
            alert_any = alert_any
                | (STATUS[i].vendor_ot & ~ALERT_MASK.int_ot)
                | (STATUS[i].temp_ot & ~ALERT_MASK.ext_ot)
                | (STATUS[i].temp_ut & ~ALERT_MASK.ext_ut);
        end
    end

    // Alert is registered so the pin never glitches on decode
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            CML_FAULT <= 1'b0;
            ALERT_N   <= 1'b1;
        end else begin
            CML_FAULT <= cml_next;
            ALERT_N   <= ~alert_any;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_bad_int_write;
        wr && hit_in && int_bad;
    endsequence

    a_int_reject: assert property (@(posedge CLOCK) disable iff (RESET)
        s_bad_int_write |=> CML_FAULT && $stable(int_reg))
        else $error("unsupported internal value accepted");
    a_retry_reject: assert property (@(posedge CLOCK) disable iff (RESET)
        wr && hit_in && w_retry != RETRY_NONE |=> CML_FAULT)
        else $error("nonzero internal retry not flagged");
    a_delay_ignored: assert property (@(posedge CLOCK) disable iff (RESET)
        wr && hit_in && w_resp[1] && w_retry == RETRY_NONE
        |=> int_reg == $past(CMD.data) && !$rose(CML_FAULT))
        else $error("delay bits changed acceptance");
    a_ext_cml: assert property (@(posedge CLOCK) disable iff (RESET)
        wr && hit_ut && ext_bad |=> CML_FAULT)
        else $error("unsupported external code not flagged");
    a_read_answer: assert property (@(posedge CLOCK) disable iff (RESET)
        rd && hit_in |=> RD_VALID && RD_DATA == $past(int_reg))
        else $error("internal setting read back wrong");
    a_alert_raise: assert property (@(posedge CLOCK) disable iff (RESET)
        STATUS[0].temp_ot && !ALERT_MASK.ext_ot |=> !ALERT_N)
        else $error("unmasked fault did not assert alert");
    a_cml_sticky: assert property (@(posedge CLOCK) disable iff (RESET)
        CML_FAULT && !CLEAR_FAULTS |=> CML_FAULT)
        else $error("communication fault dropped early");
endmodule

// File: testbench/tfr_host_model.sv
/*
 * Host model: issues one-byte action commands on the strobe port.
 * Assumes the block answers a read one cycle after the strobe is taken.
 */
`timescale 1ns/10ps
module tfr_host_model
    import tfr_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Command port
    output tfr_cmd_s        cmd,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    // ****************************************
    // Transfer
    // ****************************************
    initial cmd = '0;

    // Idle fields show the inverse of the last value, so stale data never looks valid
    task automatic xfer(input int gap, input logic wr, input logic pg, input logic [7:0] code,
                        input logic [7:0] data, output logic rv, output logic [7:0] got);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        cmd = {1'b1, wr, pg, code, data};
        @(negedge clk);
        // The read answer stands for this one cycle only, so take it here
        rv  = rd_valid;
        got = rd_data;
        cmd = {1'b0, ~wr, ~pg, ~code, ~data};
        @(negedge clk);
    endtask
endmodule

// File: testbench/tfr_tb_top.sv
/*
 * Bench for the temperature fault response block: command sequences
 * with expected values. Assumes the host model drives the command port.
 */
`timescale 1ns/10ps
module tfr_tb_top
    import tfr_pkg::*;
();
    // ****************************************
    // Signals
    // ****************************************
    logic            clk, rst, clr, int_f, rd_valid, cml, alert_n, rv;
    logic [1:0]      ot_f, ut_f, run, tick, oe;
    logic [7:0]      rd_data, got;
    tfr_cmd_s        cmd;
    tfr_mask_s       mask;
    tfr_stat_s [1:0] stat;
    int              n_mismatch, tests_run, cycles;
    // Refused writes: code in the high byte, data in the low byte
    // Last entry is an unknown command code, which is refused as well
    logic [15:0]     bad [7] = '{16'h5078, 16'h54f8, 16'hd600, 16'hd640, 16'hd6c8, 16'hd6b8,
                                 16'h5a00};

    tfr_top i_dut (.CLOCK(clk), .RESET(rst), .CMD(cmd), .RD_VALID(rd_valid),
        .RD_DATA(rd_data), .INT_OT_FAULT(int_f), .EXT_OT_FAULT(ot_f), .EXT_UT_FAULT(ut_f),
        .RUN_ON(run), .RESTART_TICK(tick), .CLEAR_FAULTS(clr), .ALERT_MASK(mask),
        .OUTPUT_ENABLE(oe), .STATUS(stat), .CML_FAULT(cml), .ALERT_N(alert_n));
    tfr_host_model i_host (.clk(clk), .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data));

    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    always #4 clk = ~clk;
    // Ceiling well above the roughly 125 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk_byte(input logic [7:0] exp, input logic [7:0] act, input string what);
        tests_run++;
        if (act !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s exp %h got %h", $time, what, exp, act);
        end
    endtask
    task automatic chk_bit(input logic exp, input logic act, input string what);
        chk_byte({7'h0, exp}, {7'h0, act}, what);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic pg, input logic [7:0] code, input logic [7:0] data);
        i_host.xfer(0, 1'b1, pg, code, data, rv, got);
        chk_bit(1'b0, rv, "no answer on write");
    endtask
    // Slow host: one idle cycle before each read
    task automatic rd(input logic pg, input logic [7:0] code, input logic [7:0] exp);
        i_host.xfer(1, 1'b0, pg, code, 8'h00, rv, got);
        chk_bit(1'b1, rv, "read answer");
        chk_byte(exp, got, "read data");
    endtask
    task automatic clear_all();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(2);
    endtask
    task automatic endt(input string name);
        $display("Test %s done", name);
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {clk, clr, int_f, ot_f, ut_f, tick, mask} = '0;
        rst = 1'b1;
        run = 2'b11;
        cyc(6);
        rst = 1'b0;
        rd(1'b0, 8'h50, 8'hb8);
        rd(1'b1, 8'h54, 8'hb8);
        rd(1'b1, 8'hd6, 8'hc0);
        endt("reset values");
        wr(1'b0, 8'h50, 8'h38);
        rd(1'b0, 8'h50, 8'h38);
        rd(1'b1, 8'h50, 8'hb8);
        foreach (bad[i]) begin
            wr(1'b0, bad[i][15:8], bad[i][7:0]);
            chk_bit(1'b1, cml, "refused write");
            chk_bit(1'b0, alert_n, "alert on fault");
            clear_all();
            chk_bit(1'b0, cml, "fault cleared");
        end
        rd(1'b0, 8'h50, 8'h38);
        rd(1'b0, 8'h54, 8'hb8);
        rd(1'b0, 8'hd6, 8'hc0);
        endt("refused writes");
        // Ch0 runs on code 00 through an external overtemp
        mask.ext_ot = 1'b1;
        ot_f[0] = 1'b1;
        cyc(2);
        chk_byte(8'h06, {2'h0, stat[0]}, "ext overtemp status");
        chk_byte(8'h00, {2'h0, stat[1]}, "other channel");
        chk_byte(8'h03, {6'h0, oe}, "code 00 runs");
        chk_bit(1'b1, alert_n, "masked source");
        mask.ext_ot = 1'b0;
        ot_f[0] = 1'b0;
        cyc(2);
        chk_bit(1'b0, alert_n, "unmasked source");
        chk_byte(8'h06, {2'h0, stat[0]}, "sticky status");
        clear_all();
        chk_byte(8'h00, {2'h0, stat[0]}, "status cleared");
        chk_bit(1'b1, alert_n, "alert released");
        // Ch1 default: off at once, restart on a tick
        ut_f[1] = 1'b1;
        cyc(2);
        chk_byte(8'h05, {2'h0, stat[1]}, "undertemp status");
        chk_byte(8'h01, {6'h0, oe}, "code 10 disables");
        ut_f[1] = 1'b0;
        cyc(2);
        chk_byte(8'h01, {6'h0, oe}, "off until tick");
        tick[1] = 1'b1;
        cyc(1);
        tick[1] = 1'b0;
        cyc(1);
        chk_byte(8'h03, {6'h0, oe}, "restart on tick");
        clear_all();
        endt("external faults");
        wr(1'b0, 8'hd6, 8'hc7);
        rd(1'b1, 8'hd6, 8'hc7);
        chk_bit(1'b0, cml, "delay bits ignored");
        int_f = 1'b1;
        cyc(2);
        chk_byte(8'h38, {2'h0, stat[1]}, "internal status");
        chk_byte(8'h00, {6'h0, oe}, "off while hot");
        int_f = 1'b0;
        cyc(2);
        chk_byte(8'h03, {6'h0, oe}, "resumes when cool");
        clear_all();
        wr(1'b0, 8'hd6, 8'h80);
        int_f = 1'b1;
        cyc(1);
        int_f = 1'b0;
        tick = 2'b11;
        cyc(1);
        tick = 2'b00;
        cyc(2);
        chk_byte(8'h00, {6'h0, oe}, "latched, no restart");
        run = 2'b00;
        cyc(2);
        run = 2'b11;
        cyc(3);
        chk_byte(8'h00, {2'h0, stat[1]}, "off-on clears");
        chk_byte(8'h03, {6'h0, oe}, "off-on restarts");
        endt("internal fault");
        give_verdict();
    end
endmodule
